// [pd_port_power_state_control.sv]
// Port power-state, fault-recovery, dead-battery and select-pin controller with APB registers
`timescale 1ns/1ps
`include "pdpsc_consts.svh"
module pd_port_power_state_control
   import pdpsc_pkg::*;
#(
   parameter int unsigned DB_PERIOD_CYC = `PDPSC_DB_PERIOD_MS * (`PDPSC_CLK_HZ / 1000),
   parameter int unsigned FAULT_OFF_CYC = `PDPSC_FAULT_OFF_US * (`PDPSC_CLK_HZ / 1000000)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_on_reset_n,
   input wire logic ext_reset_n,
   input wire logic plug_insert_n,
   input wire logic sys_fault_in,
   input wire logic vbus_present,
   input wire logic contract_ok,
   input wire logic provider_role_req,
   input wire logic profile_sel_a_in,
   output logic profile_sel_a_out,
   output logic profile_sel_a_oe_n,
   input wire logic profile_sel_b_in,
   output logic profile_sel_b_out,
   output logic profile_sel_b_oe_n,
   output logic vbus_out_en_n,
   output logic supply_fault_n_out,
   output logic supply_fault_n_oe_n,
   output logic dead_batt_supply_en,
   output logic bulk_charge_en,
   output logic low_power_standby,
   output logic negotiate_start,
   output logic rom_sclk,
   output logic rom_cs_n,
   output logic rom_mosi,
   input wire logic rom_miso
);
   logic rst_in_n;
   logic rst_meta_reg;
   logic rst_n;
   logic plug_n_s;
   logic fault_s;
   logic miso_s;
   pdpsc_state_t state_reg;
   pdpsc_state_t state_next;
   logic [1:0] ctrl_reg;
   logic [15:0] db_width_reg;
   logic [31:0] db_tmr_reg;
   logic [15:0] db_left_reg;
   logic [15:0] db_left_next;
   logic [31:0] off_tmr_reg;
   logic [15:0] retry_reg;
   logic meas_start_reg;
   logic cfg_done_reg;
   logic [7:0] cfg_num_reg;
   logic [3:0] bin_a_reg;
   logic [3:0] bin_b_reg;
   logic is_b;
   logic cfg_valid;
   logic vbus_on_next;
   logic wr_en;
   logic addr_hit;
   logic [31:0] rd_mux;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic rom_busy_reg;
   logic [3:0] rom_ph_reg;
   logic [2:0] div_reg;
   logic spi_tick;
   logic [1:0] sel_in;
   logic [1:0] sel_out;
   logic [1:0] sel_oe_n;

   // Any reset source asserts at once; release waits two flops
   assign rst_in_n = presetn && ext_reset_n && power_on_reset_n;

   always_ff @(posedge pclk or negedge rst_in_n) begin
      if (!rst_in_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   pdpsc_sync #(.W(3), .RST(3'h1)) u_pin_sync (
      .clk(pclk),
      .rst_n(rst_n),
      .d({rom_miso, sys_fault_in, plug_insert_n}),
      .q({miso_s, fault_s, plug_n_s})
   );

   // Select-pin timers, one identical instance per pin
   pdpsc_meas_if mif [2] ();
   assign sel_in = {profile_sel_b_in, profile_sel_a_in};
   assign {profile_sel_b_out, profile_sel_a_out} = sel_out;
   assign {profile_sel_b_oe_n, profile_sel_a_oe_n} = sel_oe_n;

   for (genvar i = 0; i < 2; i++) begin : g_sel
      assign mif[i].start = meas_start_reg;
      pdpsc_rc_meas u_meas (
         .clk(pclk),
         .rst_n(rst_n),
         .pin_in(sel_in[i]),
         .pin_out(sel_out[i]),
         .pin_oe_n(sel_oe_n[i]),
         .mif(mif[i])
      );
   end

   // Configuration captured once per reset
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         meas_start_reg <= 1'b1;
         cfg_done_reg <= 1'b0;
         cfg_num_reg <= 8'h00;
         bin_a_reg <= 4'h0;
         bin_b_reg <= 4'h0;
      end else begin
         meas_start_reg <= 1'b0;
         if (!cfg_done_reg && mif[0].done && mif[1].done) begin
            cfg_done_reg <= 1'b1;
            bin_a_reg <= mif[0].bin;
            bin_b_reg <= mif[1].bin;
            cfg_num_reg <= {mif[1].bin, mif[0].bin} + 8'h01;
         end
      end
   end

   assign is_b = cfg_num_reg >= `PDPSC_CFG_B_FIRST;
   assign cfg_valid = cfg_num_reg != 8'h00 && cfg_num_reg <= `PDPSC_CFG_LAST;

   // Power-state sequencing
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_CFG: begin
            if (cfg_done_reg) begin
               state_next = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if (!cfg_valid) begin
               state_next = ST_INVALID;
            end else if (is_b) begin
               state_next = ST_SINK_DISC;
            end else if (!plug_n_s) begin
               state_next = ST_SRC_ON;
            end else begin
               state_next = ST_WAIT_INSERT;
            end
         end
         ST_WAIT_INSERT: begin
            if (!plug_n_s) begin
               state_next = ST_SRC_ON;
            end
         end
         ST_SRC_ON, ST_SRC_CONTRACT: begin
            if (!is_b && plug_n_s) begin
               state_next = ST_WAIT_INSERT;
            end else if (fault_s) begin
               state_next = ST_FAULT_OFF;
            end else if (is_b && !provider_role_req) begin
               state_next = ST_SINK_RUN;
            end else begin
               state_next = contract_ok ? ST_SRC_CONTRACT : ST_SRC_ON;
            end
         end
         ST_FAULT_OFF: begin
            if (!is_b && plug_n_s) begin
               state_next = ST_WAIT_INSERT;
            end else if (off_tmr_reg == 32'(FAULT_OFF_CYC - 1)) begin
               state_next = ST_SRC_ON;
            end
         end
         ST_SINK_DISC: begin
            if (vbus_present) begin
               state_next = ST_SINK_RUN;
            end
         end
         ST_SINK_RUN: begin
            if (!vbus_present) begin
               state_next = ST_SINK_DISC;
            end else if (contract_ok && provider_role_req) begin
               state_next = ST_SRC_ON;
            end
         end
         ST_INVALID: begin
            state_next = ST_INVALID;
         end
         default: begin
            state_next = ST_INVALID;
         end
      endcase
   end

   assign vbus_on_next = state_next == ST_SRC_ON || state_next == ST_SRC_CONTRACT;

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_CFG;
         vbus_out_en_n <= 1'b1;
         bulk_charge_en <= 1'b0;
         low_power_standby <= 1'b0;
         negotiate_start <= 1'b0;
         supply_fault_n_oe_n <= 1'b1;
      end else begin
         state_reg <= state_next;
         vbus_out_en_n <= !vbus_on_next;
         bulk_charge_en <= vbus_on_next;
         low_power_standby <= state_next == ST_WAIT_INSERT || state_next == ST_SINK_DISC;
         negotiate_start <= (state_next == ST_SRC_ON && state_reg != ST_SRC_ON && state_reg != ST_SRC_CONTRACT)
            || (state_next == ST_SINK_RUN && state_reg != ST_SINK_RUN);
         supply_fault_n_oe_n <= !(state_next == ST_FAULT_OFF);
      end
   end

   assign supply_fault_n_out = 1'b0;

   // Off-time and restart count
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         off_tmr_reg <= 32'h0;
         retry_reg <= 16'h0;
      end else begin
         off_tmr_reg <= (state_reg == ST_FAULT_OFF) ? off_tmr_reg + 32'h1 : 32'h0;
         if (state_next == ST_FAULT_OFF && state_reg != ST_FAULT_OFF) begin
            retry_reg <= retry_reg + 16'h1;
         end else if (state_reg == ST_SRC_CONTRACT) begin
            retry_reg <= 16'h0;
         end
      end
   end

   // Dead-battery back-powering, only while waiting for VBUS
   always_comb begin
      db_left_next = db_left_reg;
      if (vbus_present || state_reg != ST_SINK_DISC) begin
         db_left_next = 16'h0;
      end else if (ctrl_reg[`PDPSC_CTRL_DB_EN] && db_tmr_reg == 32'(DB_PERIOD_CYC - 1)) begin
         db_left_next = db_width_reg;
      end else if (db_left_reg != 16'h0) begin
         db_left_next = db_left_reg - 16'h1;
      end
   end

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         db_tmr_reg <= 32'h0;
         db_left_reg <= 16'h0;
         dead_batt_supply_en <= 1'b0;
      end else begin
         if (state_reg != ST_SINK_DISC || !ctrl_reg[`PDPSC_CTRL_DB_EN] || db_tmr_reg == 32'(DB_PERIOD_CYC - 1)) begin
            db_tmr_reg <= 32'h0;
         end else begin
            db_tmr_reg <= db_tmr_reg + 32'h1;
         end
         db_left_reg <= db_left_next;
         dead_batt_supply_en <= db_left_next != 16'h0;
      end
   end

   // APB slave, no wait states
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign addr_hit = paddr == `PDPSC_OFF_CTRL || paddr == `PDPSC_OFF_DBW || paddr == `PDPSC_OFF_STAT
      || paddr == `PDPSC_OFF_CFG || paddr == `PDPSC_OFF_ROM || paddr == `PDPSC_OFF_RETRY;
   assign pslverr = psel && penable && !addr_hit;

   always_comb begin
      rd_mux = 32'h0;
      unique case (paddr)
         `PDPSC_OFF_CTRL: rd_mux = {30'h0, ctrl_reg};
         `PDPSC_OFF_DBW: rd_mux = {16'h0, db_width_reg};
         `PDPSC_OFF_STAT: rd_mux = {22'h0, cfg_valid, is_b, vbus_present, fault_s, !plug_n_s,
            !vbus_out_en_n, state_reg};
         `PDPSC_OFF_CFG: rd_mux = {15'h0, cfg_done_reg, cfg_num_reg, bin_b_reg, bin_a_reg};
         `PDPSC_OFF_ROM: rd_mux = {23'h0, rom_busy_reg, rx_reg};
         `PDPSC_OFF_RETRY: rd_mux = {16'h0, retry_reg};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0;
         ctrl_reg <= `PDPSC_CTRL_RST;
         db_width_reg <= `PDPSC_DBW_RST;
      end else begin
         // Captured in the setup phase so read data leaves a flop
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
         if (wr_en && paddr == `PDPSC_OFF_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end
         if (wr_en && paddr == `PDPSC_OFF_DBW) begin
            db_width_reg <= pwdata[15:0];
         end
      end
   end

   // Serial ROM master, mode 0; a write to the ROM register sends one byte
   assign spi_tick = div_reg == 3'(`PDPSC_SPI_DIV - 1);

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 3'h0;
         tx_reg <= 8'h00;
         rx_reg <= 8'h00;
         rom_busy_reg <= 1'b0;
         rom_ph_reg <= 4'h0;
         rom_sclk <= 1'b0;
         rom_cs_n <= 1'b1;
      end else begin
         div_reg <= spi_tick ? 3'h0 : div_reg + 3'h1;
         rom_cs_n <= !ctrl_reg[`PDPSC_CTRL_ROM_SEL];
         // Writes while busy are dropped; software polls the busy bit
         if (wr_en && paddr == `PDPSC_OFF_ROM && !rom_busy_reg) begin
            tx_reg <= pwdata[7:0];
            // Divider restart gives the first bit a full half period through the input flops
            div_reg <= 3'h0;
            rom_busy_reg <= 1'b1;
            rom_ph_reg <= 4'h0;
            rom_sclk <= 1'b0;
         end else if (rom_busy_reg && spi_tick) begin
            rom_sclk <= !rom_sclk;
            rom_ph_reg <= rom_ph_reg + 4'h1;
            if (!rom_sclk) begin
               rx_reg <= {rx_reg[6:0], miso_s};
            end else begin
               tx_reg <= {tx_reg[6:0], 1'b0};
            end
            if (rom_ph_reg == 4'hf) begin
               rom_busy_reg <= 1'b0;
            end
         end
      end
   end

   assign rom_mosi = tx_reg[7];

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!rst_n);

   sequence s_off_expire;
      state_reg == ST_FAULT_OFF && off_tmr_reg == 32'(FAULT_OFF_CYC - 1) && (is_b || !plug_n_s);
   endsequence
   sequence s_restart;
      state_reg == ST_SRC_ON && !vbus_out_en_n && negotiate_start;
   endsequence

   chk_plug_gate_vbus: assert property (!is_b && plug_n_s |=> vbus_out_en_n)
      else $error("VBUS enabled with no plug inserted");
   chk_insert_leaves_wait: assert property (state_reg == ST_WAIT_INSERT && !plug_n_s
      |=> state_reg == ST_SRC_ON && !vbus_out_en_n && negotiate_start && !low_power_standby)
      else $error("Plug insertion did not start the source");
   chk_fault_shutdown: assert property ((state_reg == ST_SRC_ON || state_reg == ST_SRC_CONTRACT)
      && fault_s && !plug_n_s |=> state_reg == ST_FAULT_OFF && vbus_out_en_n && !supply_fault_n_oe_n)
      else $error("Fault did not shut the supply off");
   chk_fault_restart: assert property (s_off_expire |=> s_restart)
      else $error("Supply not re-enabled after off time");
   chk_db_period: assert property (state_reg == ST_SINK_DISC && !vbus_present && ctrl_reg[0]
      && db_tmr_reg == 32'(DB_PERIOD_CYC - 1) && db_width_reg != 16'h0 |=> dead_batt_supply_en)
      else $error("Dead-battery pulse missing at period end");
   chk_db_stop_vbus: assert property (vbus_present |=> !dead_batt_supply_en)
      else $error("Dead-battery pulse during VBUS");
   chk_bulk_consumer: assert property (state_reg == ST_SINK_DISC || state_reg == ST_SINK_RUN
      |-> !bulk_charge_en && vbus_out_en_n)
      else $error("Bulk charge enabled as consumer");
   chk_cfg_hold: assert property (cfg_done_reg |=> cfg_done_reg && $stable(cfg_num_reg))
      else $error("Configuration changed after capture");
   chk_sink_resume: assert property (state_reg == ST_SINK_DISC && vbus_present
      |=> state_reg == ST_SINK_RUN && negotiate_start && !low_power_standby)
      else $error("Consumer did not resume on VBUS");
   chk_standby_wait: assert property (state_reg == ST_WAIT_INSERT |-> low_power_standby && vbus_out_en_n)
      else $error("Not in standby while waiting for plug");
endmodule : pd_port_power_state_control

// [pdpsc_consts.svh]
// Constants for the port power-state controller: offsets, fields, resets, timing
`ifndef PDPSC_CONSTS_SVH
`define PDPSC_CONSTS_SVH
`define PDPSC_CLK_HZ 50000000
`define PDPSC_DB_PERIOD_MS 10000
`define PDPSC_FAULT_OFF_US 100
`define PDPSC_DISCH_CYC 64
`define PDPSC_SPI_DIV 4
`define PDPSC_OFF_CTRL 12'h000
`define PDPSC_OFF_DBW 12'h004
`define PDPSC_OFF_STAT 12'h008
`define PDPSC_OFF_CFG 12'h00c
`define PDPSC_OFF_ROM 12'h010
`define PDPSC_OFF_RETRY 12'h014
`define PDPSC_CTRL_DB_EN 0
`define PDPSC_CTRL_ROM_SEL 1
`define PDPSC_CTRL_RST 2'h1
`define PDPSC_DBW_RST 16'h03e8
`define PDPSC_CFG_B_FIRST 8'h1f
`define PDPSC_CFG_LAST 8'h36
`endif

// [pdpsc_far.sv]
// Far-side model: supply, receptacle, select RC networks, serial ROM
`timescale 1ns/1ps
module pdpsc_far (
   input wire logic pclk,
   input wire logic plug,
   input wire logic flt,
   input wire logic vbus,
   input wire logic [15:0] ta,
   input wire logic [15:0] tbc,
   input wire logic oe_a_n,
   input wire logic oe_b_n,
   output logic plug_insert_n,
   output logic sys_fault_in,
   output logic vbus_present,
   output logic sel_a,
   output logic sel_b,
   input wire logic rom_cs_n,
   input wire logic rom_mosi,
   output logic rom_miso
);
   logic [15:0] ca = 16'h0;
   logic [15:0] cb = 16'h0;
   logic last = 1'b0;
   assign plug_insert_n = ~plug;
   assign sys_fault_in = flt; // Valid from time zero
   assign vbus_present = vbus;
   always @(posedge pclk) begin
      ca <= oe_a_n ? ca + {15'h0, ca != 16'hffff} : 16'h0;
      cb <= oe_b_n ? cb + {15'h0, cb != 16'hffff} : 16'h0;
      if (!rom_cs_n) last <= rom_mosi;
   end
   // Crossing time stands in for the fitted bin
   assign sel_a = oe_a_n && ca >= ta;
   assign sel_b = oe_b_n && cb >= tbc;
   // Deselected ROM shows the inverse, so a stale bit never passes
   assign rom_miso = rom_cs_n ? ~last : rom_mosi;
endmodule : pdpsc_far

// [pdpsc_meas_if.sv]
// Start/result bundle between the controller and one select-pin timer
`timescale 1ns/1ps
interface pdpsc_meas_if;
   logic start;
   logic done;
   logic [3:0] bin;
   modport ctrl (output start, input done, input bin);
   modport meas (input start, output done, output bin);
endinterface : pdpsc_meas_if

// [pdpsc_pkg.sv]
// Types shared by the port power-state controller modules
package pdpsc_pkg;
   typedef enum logic [3:0] {ST_CFG, ST_STARTUP, ST_WAIT_INSERT, ST_SRC_ON, ST_SRC_CONTRACT,
      ST_FAULT_OFF, ST_SINK_DISC, ST_SINK_RUN, ST_INVALID} pdpsc_state_t;
   typedef enum logic [1:0] {M_IDLE, M_DISCH, M_CHARGE, M_DONE} pdpsc_meas_t;
endpackage : pdpsc_pkg

// [pdpsc_rc_meas.sv]
// RC charge-time measurement and bin classification for one select pin
`timescale 1ns/1ps
`include "pdpsc_consts.svh"
module pdpsc_rc_meas
   import pdpsc_pkg::*;
#(
   parameter int CW = 20,
   // Crossing-time bin edges in clock cycles, geometric midpoints of the network time constants
   parameter logic [CW-1:0] EDGE [0:14] = '{20'h00014, 20'h00055, 20'h00099, 20'h0010f, 20'h001df,
      20'h00354, 20'h005f6, 20'h00a9a, 20'h012b8, 20'h0214a, 20'h03b9d, 20'h06a03, 20'h0bb2f,
      20'h14cdf, 20'h25422}
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_n,
   pdpsc_meas_if.meas mif
);
   pdpsc_meas_t st_reg;
   logic [CW-1:0] cnt_reg;
   logic pin_s;
   logic [3:0] bin_next;

   pdpsc_sync #(.W(1), .RST(1'b0)) u_pin_sync (.clk(clk), .rst_n(rst_n), .d(pin_in), .q(pin_s));

   assign pin_out = 1'b0;

   // Bin = number of edges the crossing time exceeds
   always_comb begin
      bin_next = 4'h0;
      for (int i = 0; i < 15; i++) begin
         if (cnt_reg > EDGE[i]) begin
            bin_next = bin_next + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= M_IDLE;
         cnt_reg <= '0;
         pin_oe_n <= 1'b1;
         mif.done <= 1'b0;
         mif.bin <= 4'h0;
      end else begin
         unique case (st_reg)
            M_IDLE: begin
               if (mif.start) begin
                  st_reg <= M_DISCH;
                  pin_oe_n <= 1'b0;
                  cnt_reg <= '0;
               end
            end
            M_DISCH: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == CW'(`PDPSC_DISCH_CYC - 1)) begin
                  st_reg <= M_CHARGE;
                  pin_oe_n <= 1'b1;
                  cnt_reg <= '0;
               end
            end
            M_CHARGE: begin
               // Saturation counts as the slowest bin
               if (pin_s || &cnt_reg) begin
                  st_reg <= M_DONE;
                  mif.bin <= bin_next;
                  mif.done <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            M_DONE: begin
               mif.done <= 1'b1;
            end
         endcase
      end
   end
endmodule : pdpsc_rc_meas

// [pdpsc_sync.sv]
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pdpsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RST;
         q <= RST;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : pdpsc_sync

// [tb.sv]
// Self-checking bench for the port power-state controller
`timescale 1ns/1ps
module tb;
   localparam int DB = 200;
   localparam int FO = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic power_on_reset_n, ext_reset_n, plug_insert_n, sys_fault_in, vbus_present, contract_ok;
   logic provider_role_req, profile_sel_a_in, profile_sel_a_out, profile_sel_a_oe_n, profile_sel_b_in;
   logic profile_sel_b_out, profile_sel_b_oe_n, vbus_out_en_n, supply_fault_n_out, supply_fault_n_oe_n;
   logic dead_batt_supply_en, bulk_charge_en, low_power_standby, negotiate_start;
   logic rom_sclk, rom_cs_n, rom_mosi, rom_miso, plug, flt, vbus;
   logic [15:0] ta, tbc;
   int err_count = 0;
   int check_count = 0;
   int c;
   pd_port_power_state_control #(.DB_PERIOD_CYC(DB), .FAULT_OFF_CYC(FO)) u_pd_port_power_state_control (.*);
   pdpsc_far u_pdpsc_far (.pclk(pclk), .plug(plug), .flt(flt), .vbus(vbus), .ta(ta), .tbc(tbc),
      .oe_a_n(profile_sel_a_oe_n), .oe_b_n(profile_sel_b_oe_n), .plug_insert_n(plug_insert_n),
      .sys_fault_in(sys_fault_in), .vbus_present(vbus_present), .sel_a(profile_sel_a_in),
      .sel_b(profile_sel_b_in), .rom_cs_n(rom_cs_n), .rom_mosi(rom_mosi), .rom_miso(rom_miso));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic b(input string n, input logic s, input logic e);
      chk(n, {31'h0, s}, {31'h0, e});
   endtask : b
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Counts falling edges until the level shows, bounded
   task automatic wt(ref logic s, input logic v);
      c = 0;
      do begin
         @(negedge pclk);
         c++;
      end while (s !== v && c < 1000);
      // A wait that runs out is a mismatch of its own
      if (s !== v) b("wait_level", s, v);
   endtask : wt
   task automatic t_defaults;
      b("vbus_off", vbus_out_en_n, 1'b1);
      b("rom_cs", rom_cs_n, 1'b1);
      b("db_off", dead_batt_supply_en, 1'b0);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", rd, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk("dbw", rd, 32'h3e8);
      apb(1'b0, 12'h020, 32'h0);
      b("unmapped", err, 1'b1);
   endtask : t_defaults
   task automatic t_src;
      wt(low_power_standby, 1'b1);
      b("stby", low_power_standby, 1'b1);
      b("no_vbus", vbus_out_en_n, 1'b1);
      apb(1'b0, 12'h00c, 32'h0);
      chk("cfg_a", rd & 32'h1ffff, 32'h10100);
      plug <= 1'b1;
      wt(vbus_out_en_n, 1'b0);
      b("src_on", c < 8, 1'b1);
      b("neg", negotiate_start, 1'b1);
      b("bulk", bulk_charge_en, 1'b1);
      b("wake", low_power_standby, 1'b0);
      @(negedge pclk);
      b("neg_once", negotiate_start, 1'b0);
   endtask : t_src
   task automatic t_fault;
      @(posedge pclk);
      flt <= 1'b1;
      wt(vbus_out_en_n, 1'b1);
      b("flt_off", c < 6, 1'b1);
      b("flt_pin", supply_fault_n_oe_n, 1'b0);
      b("flt_drv", supply_fault_n_out, 1'b0);
      b("flt_bulk", bulk_charge_en, 1'b0);
      wt(vbus_out_en_n, 1'b0);
      chk("off_len", c, FO);
      b("renego", negotiate_start, 1'b1);
      wt(vbus_out_en_n, 1'b1);
      b("again", c < 3, 1'b1);
      @(posedge pclk);
      flt <= 1'b0;
      wt(vbus_out_en_n, 1'b0);
      b("recover", c <= FO, 1'b1);
      b("flt_clr", supply_fault_n_oe_n, 1'b1);
      apb(1'b0, 12'h014, 32'h0);
      chk("retry_cnt", rd, 32'h2);
      contract_ok <= 1'b1;
      apb(1'b0, 12'h008, 32'h0);
      chk("contract", rd & 32'hf, 32'h4);
      apb(1'b0, 12'h014, 32'h0);
      chk("retry", rd, 32'h0);
      plug <= 1'b0;
      wt(vbus_out_en_n, 1'b1);
      b("unplug", low_power_standby, 1'b1);
   endtask : t_fault
   task automatic t_sink;
      @(posedge pclk);
      tbc <= 16'd120;
      contract_ok <= 1'b0;
      ext_reset_n <= 1'b0;
      repeat (3) @(posedge pclk);
      b("rst_vbus", vbus_out_en_n, 1'b1);
      ext_reset_n <= 1'b1;
      wt(low_power_standby, 1'b1);
      // Select network changes after measurement must be ignored
      @(posedge pclk);
      ta <= 16'd300;
      apb(1'b0, 12'h00c, 32'h0);
      chk("cfg_b", rd & 32'h1ffff, 32'h12120);
      b("sel_rel", profile_sel_a_oe_n & profile_sel_b_oe_n, 1'b1);
      b("sel_out", profile_sel_a_out | profile_sel_b_out, 1'b0);
      apb(1'b0, 12'h008, 32'h0);
      chk("sink", rd & 32'h10f, 32'h106);
      b("sink_bulk", bulk_charge_en, 1'b0);
      apb(1'b1, 12'h004, 32'h5);
      wt(dead_batt_supply_en, 1'b1);
      b("db_pulse", c <= DB + 2, 1'b1);
      wt(dead_batt_supply_en, 1'b0);
      chk("db_width", c, 5);
      apb(1'b1, 12'h004, 32'h32);
      wt(dead_batt_supply_en, 1'b1);
      @(posedge pclk);
      vbus <= 1'b1;
      wt(dead_batt_supply_en, 1'b0);
      b("db_stop", c < 3, 1'b1);
      b("sink_run", low_power_standby, 1'b0);
      b("sink_neg", negotiate_start, 1'b1);
      // Role swap to provider and back
      @(posedge pclk);
      contract_ok <= 1'b1;
      provider_role_req <= 1'b1;
      wt(vbus_out_en_n, 1'b0);
      b("swap_src", bulk_charge_en, 1'b1);
      @(posedge pclk);
      provider_role_req <= 1'b0;
      wt(bulk_charge_en, 1'b0);
      b("swap_sink", vbus_out_en_n, 1'b1);
   endtask : t_sink
   task automatic t_rom;
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b1, 12'h010, 32'ha5);
      b("rom_sel", rom_cs_n, 1'b0);
      c = 0;
      do begin
         apb(1'b0, 12'h010, 32'h0);
         c++;
      end while (rd[8] !== 1'b0 && c < 50);
      chk("rom_rx", rd & 32'h1ff, 32'ha5);
      b("sclk_idle", rom_sclk, 1'b0);
      power_on_reset_n <= 1'b0;
      repeat (3) @(posedge pclk);
      power_on_reset_n <= 1'b1;
      repeat (3) @(posedge pclk);
      t_defaults;
      // Fresh measurement picks up the select network changed before this reset
      wt(negotiate_start, 1'b1);
      apb(1'b0, 12'h00c, 32'h0);
      chk("cfg_new", rd & 32'h1ffff, 32'h12524);
   endtask : t_rom
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      power_on_reset_n = 1'b1;
      ext_reset_n = 1'b1;
      plug = 1'b0;
      flt = 1'b0;
      vbus = 1'b0;
      contract_ok = 1'b0;
      provider_role_req = 1'b0;
      ta = 16'd8;
      tbc = 16'd8;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      t_defaults;
      t_src;
      t_fault;
      t_sink;
      t_rom;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      end_sim;
   end
endmodule : tb
